/* ddrtp_regs.svh */
// Purpose: register map, field ranges and reset values for the
//          DDR termination and PHY control block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   field ranges are given as msb:lsb for part-selects
//
// Behaviour
// R1 - hold mode register 3 value for init
// R2 - read termination extend adds one cycle
// R3 - read select: 0 none, 2, 4 decoded
// R4 - write termination extend adds one cycle
// R5 - write select: 0 none, 3, 9, 12 decoded
// R6 - local read termination extend one cycle
// R7 - local read termination only when enabled
// R8 - two strobe delay copies, lane 0 first
// R9 - capture window: fixed delay plus offset
// R10 - software keeps reserved delay bits at 3
// R11 - fifo soft reset holds interface fifos
// R12 - master reset holds phy, resets set
// R13 - pin drive only when enable bit set
// R14 - stub series mode bit, reset set
// R15 - calibration start, cleared on completion
// R16 - termination impedance code, reset 3
// R17 - drive strength code, reset 11
// R18 - software sets codes before calibration start
// R19 - read termination after programmed delay
// R20 - write termination after programmed delay
// R21 - local termination delay plus lane offset
// R22 - reserved selects drive no termination
`ifndef DDRTP_REGS_SVH
`define DDRTP_REGS_SVH
// byte offsets
`define DT_OFF_MR3   8'h00
`define DT_OFF_TERM  8'h04
`define DT_OFF_DLY0  8'h08
`define DT_OFF_DLY1  8'h0c
`define DT_OFF_PHY   8'h10
`define DT_OFF_ZCAL  8'h14
`define DT_OFF_TDLY  8'h18
// reset values
`define DT_MR3_RST   16'h0000
`define DT_TERM_RST  12'h000
`define DT_DLY_RST   11'h360
`define DT_IFACE_MASTER_RESET   8'h03
`define DT_ZCAL_RST  9'h076
`define DT_TDLY_RST  16'h0000
// select encodings
`define DT_RSEL_CS1  4'h2
`define DT_RSEL_CS0  4'h4
`define DT_WSEL_ANY0 4'h3
`define DT_WSEL_OWN  4'h9
`define DT_WSEL_ANY1 4'hc
// termination window base length in cycles
`define DT_BURST_CYC 2
`endif

/* ddrtp_pkg.sv */
// Purpose: register layout types for the termination/PHY block
// Assumes: field order msb first matches the register bits
// Notes:   none
package ddrtp_pkg;
    typedef logic [3:0] ddrtp_code_t;
    typedef struct packed {
        logic        rd_ext;
        logic [3:0]  rd_sel;
        logic        wr_ext;
        logic [3:0]  wr_sel;
        logic        lrd_ext;
        logic        lrd_en;
    } ddrtp_term_t;
    typedef struct packed {
        logic [2:0]  rsv_hi;
        logic [2:0]  rsv_lo;
        logic [4:0]  offs;
    } ddrtp_dly_t;
    typedef struct packed {
        logic        fifo_rst;
        logic [1:0]  pad;
        logic        odt_oe;
        logic        ck_oe;
        logic        cl_oe;
        logic        sstl;
        logic        rst;
    } ddrtp_phy_t;
    typedef struct packed {
        ddrtp_code_t term;
        ddrtp_code_t drive;
        logic        start;
    } ddrtp_zcal_t;
    typedef struct packed {
        logic [3:0]  rd;
        logic [3:0]  wr;
        logic [3:0]  lrd;
        logic [3:0]  fixed;
    } ddrtp_tdly_t;
endpackage

/* ddrtp_ctrl.sv */
// Purpose: termination, strobe window and PHY control registers
// Assumes: read/write command strobes come from the same clock
// Notes:   cal_clk and cal_done are asynchronous, sampled here
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "ddrtp_regs.svh"
module ddrtp_ctrl (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst_n,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // command engine
    input  wire logic                rd_cmd,
    input  wire logic                wr_cmd,
    input  wire logic                cmd_cs,
    // calibration engine link
    input  wire logic                cal_clk,
    input  wire logic                cal_done,
    output logic                     cal_req,
    output ddrtp_pkg::ddrtp_code_t   term_impedance_code,
    output ddrtp_pkg::ddrtp_code_t   drive_strength_code,
    // phy controls
    output logic      [15:0]         mode_reg3_value,
    output logic      [1:0]          odt,
    output logic                     term_pin_output_enable,
    output logic                     clock_pin_output_enable,
    output logic                     command_lane_output_enable,
    output logic                     stub_series_mode_enable,
    output logic                     iface_master_reset,
    output logic                     iface_fifo_soft_reset,
    // per byte lane
    output logic      [1:0]          local_term,
    output logic      [1:0]          capture_win,
    output logic      [3:0]          capture_phase
);
    import ddrtp_pkg::*;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // register storage
    logic [15:0]  mr3_r;        // mode register 3 image
    ddrtp_term_t  term_r;       // termination control
    ddrtp_dly_t   dly_r [2];    // strobe delay per lane
    ddrtp_phy_t   phy_r;        // phy configuration
    ddrtp_zcal_t  zcal_r;       // impedance calibration
    ddrtp_tdly_t  tdly_r;       // termination delays
    // apb state
    logic [31:0]  rdata_nxt;    // read mux
    logic         hit;          // mapped address
    logic         wr_acc;       // write takes effect
    logic         setup;        // setup phase
    // calibration link sync
    logic         cclk_s1_r;
    logic         cclk_s2_r;
    logic         cclk_s3_r;
    logic         done_s1_r;
    logic         done_s2_r;
    logic         done_evt;     // completion seen
    // command history per chip select
    logic [31:0]  rh_r [2];
    logic [31:0]  wh_r [2];
    logic [31:0]  rv [2];       // history incl. now
    logic [31:0]  wv [2];
    logic [31:0]  rany;         // any read
    logic [31:0]  wany;         // any write
    logic [1:0]   odt_nxt;
    logic [1:0]   odt_r;
    logic [1:0]   lt_nxt;
    logic [1:0]   lt_r;
    logic [1:0]   cw_nxt;
    logic [1:0]   cw_r;
    logic [3:0]   ph_r;
    logic         cal_req_r;
    logic [31:0]  prdata_r;
    logic         pready_r;
    logic         pslverr_r;

    // window of burst length at delay d, plus one if extended
    function automatic logic win(input logic [31:0] v,
                                 input logic [4:0]  d,
                                 input logic        ext);
        logic r;
        r = 1'b0;
        for (int k = 0; k < `DT_BURST_CYC; k++) begin
            r = r | v[5'(d + 5'(k))];
        end
        return r | (ext & v[5'(d + 5'(`DT_BURST_CYC))]);
    endfunction

    // apb decode
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & pready_r & hit;

    // read mux, unmapped reads zero
    always_comb begin
        hit       = 1'b1;
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `DT_OFF_MR3:  rdata_nxt = {16'h0000, mr3_r};
            `DT_OFF_TERM: rdata_nxt = {20'h00000, term_r};
            `DT_OFF_DLY0: rdata_nxt = {21'h0, dly_r[0]};
            `DT_OFF_DLY1: rdata_nxt = {21'h0, dly_r[1]};
            `DT_OFF_PHY:  rdata_nxt = {24'h000000, phy_r};
            `DT_OFF_ZCAL: rdata_nxt = {23'h0, zcal_r};
            `DT_OFF_TDLY: rdata_nxt = {16'h0000, tdly_r};
            default:      hit = 1'b0;
        endcase
    end

    // one wait-free access phase: answer prepared in setup
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (setup) begin
            pready_r  <= 1'b1;
            pslverr_r <= ~hit;
            prdata_r  <= pwrite ? 32'h0000_0000 : rdata_nxt;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // mode register 3 image
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mr3_r <= `DT_MR3_RST;
        end else if (wr_acc && paddr == `DT_OFF_MR3) begin
            mr3_r <= pwdata[15:0]; // see R1
        end
    end

    // termination control and delays
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            term_r <= `DT_TERM_RST;
            tdly_r <= `DT_TDLY_RST;
        end else if (wr_acc) begin
            if (paddr == `DT_OFF_TERM) begin
                term_r <= pwdata[11:0];
            end
            if (paddr == `DT_OFF_TDLY) begin
                tdly_r <= pwdata[15:0];
            end
        end
    end

    // strobe delay, one copy per lane
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dly_r[0] <= `DT_DLY_RST; // see R8
            dly_r[1] <= `DT_DLY_RST;
        end else if (wr_acc) begin
            if (paddr == `DT_OFF_DLY0) begin
                dly_r[0] <= pwdata[10:0];
            end
            if (paddr == `DT_OFF_DLY1) begin
                dly_r[1] <= pwdata[10:0];
            end
        end
    end

    // phy configuration, master reset and sstl set at reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phy_r <= `DT_IFACE_MASTER_RESET; // see R12 see R14
        end else if (wr_acc && paddr == `DT_OFF_PHY) begin
            // unused bits 6:5 always stored as zero
            phy_r <= {pwdata[7], 2'b00, pwdata[4:0]};
        end
    end

    // calibration link: two flops before any use
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cclk_s1_r <= 1'b0;
            cclk_s2_r <= 1'b0;
            cclk_s3_r <= 1'b0;
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
        end else begin
            cclk_s1_r <= cal_clk;
            cclk_s2_r <= cclk_s1_r;
            cclk_s3_r <= cclk_s2_r;
            done_s1_r <= cal_done;
            done_s2_r <= done_s1_r;
        end
    end

    // done sampled on a rising link clock edge
    assign done_evt = cclk_s2_r & ~cclk_s3_r & done_s2_r & zcal_r.start;

    // calibration register; a new start beats completion
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            zcal_r <= `DT_ZCAL_RST; // see R16 see R17
        end else begin
            if (done_evt) begin
                zcal_r.start <= 1'b0; // see R15
            end
            if (wr_acc && paddr == `DT_OFF_ZCAL) begin
                zcal_r.term  <= pwdata[8:5];
                zcal_r.drive <= pwdata[4:1];
                if (pwdata[0]) begin
                    zcal_r.start <= 1'b1; // see R15 see R18
                end
            end
        end
    end

    // request level follows the start bit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_req_r <= 1'b0;
        end else begin
            cal_req_r <= zcal_r.start;
        end
    end

    // command history per chip select
    for (genvar g = 0; g < 2; g++) begin : g_cs
        assign rv[g] = {rh_r[g][30:0], rd_cmd & (cmd_cs == 1'(g))};
        assign wv[g] = {wh_r[g][30:0], wr_cmd & (cmd_cs == 1'(g))};
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                rh_r[g] <= 32'h0000_0000;
                wh_r[g] <= 32'h0000_0000;
            end else begin
                rh_r[g] <= rv[g];
                wh_r[g] <= wv[g];
            end
        end
    end

    assign rany = rv[0] | rv[1];
    assign wany = wv[0] | wv[1];

    // external termination decode; reserved selects give nothing
    always_comb begin
        odt_nxt = 2'b00; // see R22
        // reads: delay field, extend bit
        if (term_r.rd_sel == `DT_RSEL_CS1) begin
            odt_nxt[0] = win(rv[1], 5'(tdly_r.rd), term_r.rd_ext); // see R3 see R19 see R2
        end
        if (term_r.rd_sel == `DT_RSEL_CS0) begin
            odt_nxt[1] = win(rv[0], 5'(tdly_r.rd), term_r.rd_ext); // see R3 see R19 see R2
        end
        // writes
        case (term_r.wr_sel)
            `DT_WSEL_ANY0: begin
                odt_nxt[0] = odt_nxt[0] | win(wany, 5'(tdly_r.wr), term_r.wr_ext); // see R5
            end
            `DT_WSEL_OWN: begin
                odt_nxt[0] = odt_nxt[0] | win(wv[0], 5'(tdly_r.wr), term_r.wr_ext); // see R20
                odt_nxt[1] = odt_nxt[1] | win(wv[1], 5'(tdly_r.wr), term_r.wr_ext); // see R4
            end
            `DT_WSEL_ANY1: begin
                odt_nxt[1] = odt_nxt[1] | win(wany, 5'(tdly_r.wr), term_r.wr_ext); // see R5
            end
            default: begin
            end
        endcase
        // pin quiet unless driven and phy out of reset
        if (!phy_r.odt_oe || phy_r.rst) begin
            odt_nxt = 2'b00; // see R13 see R12
        end
    end

    // per lane local termination and capture window
    for (genvar l = 0; l < 2; l++) begin : g_lane
        // local termination only while enabled and out of reset
        assign lt_nxt[l] = term_r.lrd_en & ~phy_r.rst & // see R7
            win(rany, 5'(tdly_r.lrd) + 5'(dly_r[l].offs[4:2]),
                term_r.lrd_ext); // see R21 see R6
        // one-cycle capture window at fixed delay plus whole cycles
        assign cw_nxt[l] = ~phy_r.rst & rany[5'(tdly_r.fixed) +
                                             5'(dly_r[l].offs[4:2])]; // see R9
    end

    // registered pin outputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            odt_r <= 2'b00;
            lt_r  <= 2'b00;
            cw_r  <= 2'b00;
            ph_r  <= 4'h0;
        end else begin
            odt_r <= odt_nxt;
            lt_r  <= lt_nxt;
            cw_r  <= cw_nxt;
            ph_r  <= {dly_r[1].offs[1:0], dly_r[0].offs[1:0]}; // see R9
        end
    end

    // outputs straight from flops
    assign prdata                     = prdata_r;
    assign pready                     = pready_r;
    assign pslverr                    = pslverr_r;
    assign mode_reg3_value            = mr3_r;
    assign odt                        = odt_r;
    assign local_term                 = lt_r;
    assign capture_win                = cw_r;
    assign capture_phase              = ph_r;
    assign cal_req                    = cal_req_r;
    assign term_impedance_code        = zcal_r.term;
    assign drive_strength_code        = zcal_r.drive;
    assign term_pin_output_enable     = phy_r.odt_oe;
    assign clock_pin_output_enable    = phy_r.ck_oe;
    assign command_lane_output_enable = phy_r.cl_oe;
    assign stub_series_mode_enable    = phy_r.sstl;
    assign iface_master_reset         = phy_r.rst;
    assign iface_fifo_soft_reset      = phy_r.fifo_rst; // see R11

    // checks
    // a landed write shows on the init sequencer port next cycle
    chk_mr3_write: assert property ( // see R1
        wr_acc && paddr == `DT_OFF_MR3 |=> mode_reg3_value == $past(pwdata[15:0])
    ) else $error("mode register 3 image not updated");

    chk_rd_cs1: assert property ( // see R3
        term_r.rd_sel == `DT_RSEL_CS1 && phy_r.odt_oe && !phy_r.rst
        && rv[1][tdly_r.rd] |=> odt[0]
    ) else $error("read termination for cs1 missing");

    // code 0 and reserved codes alike must leave both pins quiet
    chk_reserved_sel: assert property ( // see R22
        !(term_r.rd_sel inside {`DT_RSEL_CS1, `DT_RSEL_CS0})
        && !(term_r.wr_sel inside {`DT_WSEL_ANY0, `DT_WSEL_OWN, `DT_WSEL_ANY1})
        |=> odt == 2'b00
    ) else $error("reserved select drove termination");

    chk_wr_ext: assert property ( // see R4
        term_r.wr_sel == `DT_WSEL_ANY1 && term_r.wr_ext && phy_r.odt_oe
        && !phy_r.rst && wany[5'(tdly_r.wr) + 5'(`DT_BURST_CYC)] |=> odt[1]
    ) else $error("write termination extend missing");

    chk_odt_gate: assert property ( // see R13
        !phy_r.odt_oe || phy_r.rst |=> odt == 2'b00
    ) else $error("termination driven while disabled");

    chk_local_gate: assert property ( // see R7
        !term_r.lrd_en |=> local_term == 2'b00
    ) else $error("local termination without enable");

    chk_cap_lane0: assert property ( // see R9
        !phy_r.rst && rany[5'(tdly_r.fixed) + 5'(dly_r[0].offs[4:2])]
        |=> capture_win[0] && capture_phase[1:0] == $past(dly_r[0].offs[1:0])
    ) else $error("lane 0 capture window misplaced");

    // a fresh start must reach the engine request one cycle later
    chk_cal_start: assert property ( // see R15
        wr_acc && paddr == `DT_OFF_ZCAL && pwdata[0] |=> zcal_r.start ##1 cal_req
    ) else $error("calibration start not raised");

    chk_cal_clear: assert property ( // see R15
        done_evt && !(wr_acc && paddr == `DT_OFF_ZCAL && pwdata[0])
        |=> !zcal_r.start ##1 !cal_req
    ) else $error("calibration start not cleared");

    chk_apb_answer: assert property (
        setup |=> pready ##1 !pready
    ) else $error("apb answer not one cycle");

endmodule

/* ddrtp_cal_model.sv */
// Purpose: calibration engine stand-in on the far side of the cal link
// Assumes: cal_req stays high until the block has seen done
// Notes:   link clock toggles only while a calibration is in flight
`timescale 1ns/100ps
module ddrtp_cal_model #(
    parameter int TICKS = 3  // link clocks before done
) (
    // request from the block
    input  wire logic cal_req,
    // link back to the block
    output logic      cal_clk,
    output logic      cal_done
);
    // one 320 ns link clock period
    task automatic tick();
        #160 cal_clk = 1'b1;
        #160 cal_clk = 1'b0;
    endtask
    // idle link: clock parked low, no done; then serve requests,
    // done held until the request falls
    initial begin
        cal_clk  = 1'b0;
        cal_done = 1'b0;
        forever begin
            wait (cal_req === 1'b1);
            #7;                          // phase unrelated to the block clock
            repeat (TICKS) tick();
            cal_done = 1'b1;
            while (cal_req === 1'b1) tick();
            cal_done = 1'b0;             // dropped before any new request
        end
    end
endmodule

/* testbench.sv */
// Purpose: self-checking bench for the termination and phy control block
// Assumes: apb slave answers after one access cycle at the earliest
// Notes:   observation windows index cycle after the command edge
`timescale 1ns/100ps
`include "ddrtp_regs.svh"
module testbench;
    import ddrtp_pkg::*;
    // clock, reset, apb
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    // commands and cal link
    logic rd_cmd, wr_cmd, cmd_cs, cal_clk, cal_done, cal_req;
    // observed outputs
    ddrtp_code_t term_impedance_code, drive_strength_code;
    logic [15:0] mode_reg3_value;
    logic [1:0] odt, local_term, capture_win;
    logic [3:0] capture_phase;
    logic term_pin_output_enable, clock_pin_output_enable, command_lane_output_enable;
    logic stub_series_mode_enable, iface_master_reset, iface_fifo_soft_reset;
    // bench state
    int n_fail, tests_run;
    logic live;                           // odt expected to reach the pins
    logic [7:0][1:0] o_odt, o_lt, o_cw;   // per-cycle samples
    ddrtp_ctrl u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rd_cmd, .wr_cmd, .cmd_cs, .cal_clk, .cal_done, .cal_req,
        .term_impedance_code, .drive_strength_code, .mode_reg3_value, .odt,
        .term_pin_output_enable, .clock_pin_output_enable, .command_lane_output_enable,
        .stub_series_mode_enable, .iface_master_reset, .iface_fifo_soft_reset,
        .local_term, .capture_win, .capture_phase);
    ddrtp_cal_model u_cal (.cal_req, .cal_clk, .cal_done);
    // 25 MHz clock
    always #20 clock = ~clock;
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);     // a hang is left to the watchdog
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    // pulse one command, sample eight cycles
    task run_cmd(input logic r, input logic cs);
        @(posedge clock);
        rd_cmd <= r;
        wr_cmd <= ~r;
        cmd_cs <= cs;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            rd_cmd <= 1'b0;
            wr_cmd <= 1'b0;
            @(negedge clock);
            o_odt[i] = odt;
            o_lt[i] = local_term;
            o_cw[i] = capture_win;
        end
    endtask
    // expected pins for a select code
    function automatic logic [1:0] pins(input logic r, input logic cs, input logic [3:0] s);
        if (r) return (s == 4'h2 && cs) ? 2'b01 : (s == 4'h4 && !cs) ? 2'b10 : 2'b00;
        case (s)
            4'h3: return 2'b01;
            4'h9: return cs ? 2'b10 : 2'b01;
            4'hc: return 2'b10;
            default: return 2'b00;       // reserved codes stay quiet
        endcase
    endfunction
    // one termination case: select, extend, delay field
    task odt_case(input logic r, input logic cs, input logic [3:0] s, input logic x,
                  input logic [3:0] dl);
        logic [7:0][1:0] e;
        wr(`DT_OFF_TERM, r ? {20'h0, x, s, 7'h0} : {25'h0, x, s, 2'b00});
        wr(`DT_OFF_TDLY, r ? {16'h0, dl, 12'h0} : {20'h0, dl, 8'h0});
        run_cmd(r, cs);
        for (int i = 0; i < 8; i++) begin
            e[i] = (live && i >= dl && i < dl + 2 + x) ? pins(r, cs, s) : 2'b00;
        end
        chk({16'h0, o_odt}, {16'h0, e});
    endtask
    // local termination and capture window on both lanes
    task lane_case(input logic en, input logic x, input logic [3:0] ld, input logic [3:0] fx,
                   input logic [4:0] o0, input logic [4:0] o1);
        logic [7:0][1:0] el, ec;
        logic [4:0] o [2];
        o[0] = o0;
        o[1] = o1;
        wr(`DT_OFF_TERM, {30'h0, x, en});
        wr(`DT_OFF_TDLY, {24'h0, ld, fx});
        wr(`DT_OFF_DLY0, {21'h0, 6'h1b, o0});
        wr(`DT_OFF_DLY1, {21'h0, 6'h1b, o1});
        run_cmd(1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            for (int l = 0; l < 2; l++) begin
                el[i][l] = en && i >= ld + o[l][4:2] && i < ld + o[l][4:2] + 2 + x;
                ec[i][l] = (i == fx + o[l][4:2]);
            end
        end
        chk({16'h0, o_lt}, {16'h0, el});
        chk({16'h0, o_cw}, {16'h0, ec});
        chk({28'h0, capture_phase}, {28'h0, o1[1:0], o0[1:0]});
    endtask
    task t_reset();
        rd(`DT_OFF_MR3, 32'h0, 1'b0);
        rd(`DT_OFF_TERM, 32'h0, 1'b0);
        rd(`DT_OFF_DLY0, 32'h360, 1'b0);
        rd(`DT_OFF_DLY1, 32'h360, 1'b0);
        rd(`DT_OFF_PHY, 32'h3, 1'b0);
        rd(`DT_OFF_ZCAL, 32'h76, 1'b0);
        rd(`DT_OFF_TDLY, 32'h0, 1'b0);
        rd(8'h1c, 32'h0, 1'b1);
        chk({26'h0, iface_master_reset, stub_series_mode_enable, term_pin_output_enable,
             clock_pin_output_enable, command_lane_output_enable, iface_fifo_soft_reset},
            32'h30);
        chk({24'h0, term_impedance_code, drive_strength_code}, 32'h3b);
        $display("done: reset values");
    endtask
    task t_regs();
        wr(`DT_OFF_MR3, 32'hffffa5c3);
        rd(`DT_OFF_MR3, 32'ha5c3, 1'b0);
        chk({16'h0, mode_reg3_value}, 32'ha5c3);
        wr(8'h1c, 32'h1234);
        rd(`DT_OFF_MR3, 32'ha5c3, 1'b0);
        wr(`DT_OFF_PHY, 32'hfe);
        rd(`DT_OFF_PHY, 32'h9e, 1'b0);
        chk({26'h0, iface_fifo_soft_reset, term_pin_output_enable, clock_pin_output_enable,
             command_lane_output_enable, stub_series_mode_enable, iface_master_reset},
            32'h3e);
        wr(`DT_OFF_PHY, 32'h1e);
        $display("done: register access");
    endtask
    task t_odt();
        live = 1'b1;
        for (int r = 0; r < 2; r++) begin
            for (int s = 0; s < 16; s++) begin
                odt_case(r[0], 1'b0, s[3:0], 1'b0, 4'h0);
                odt_case(r[0], 1'b1, s[3:0], 1'b0, 4'h0);
            end
        end
        odt_case(1'b1, 1'b1, 4'h2, 1'b1, 4'h0);
        odt_case(1'b0, 1'b0, 4'h3, 1'b1, 4'h0);
        odt_case(1'b0, 1'b1, 4'hc, 1'b1, 4'h1);
        odt_case(1'b1, 1'b0, 4'h4, 1'b0, 4'h3);
        odt_case(1'b0, 1'b1, 4'h9, 1'b0, 4'h2);
        odt_case(1'b0, 1'b0, 4'h5, 1'b0, 4'h0);
        wr(`DT_OFF_PHY, 32'h0e);
        live = 1'b0;
        odt_case(1'b0, 1'b0, 4'h3, 1'b0, 4'h0);
        wr(`DT_OFF_PHY, 32'h1f);
        odt_case(1'b0, 1'b1, 4'hc, 1'b0, 4'h0);
        wr(`DT_OFF_PHY, 32'h1e);
        $display("done: termination pins");
    endtask
    task t_lane();
        lane_case(1'b1, 1'b0, 4'h0, 4'h0, 5'h00, 5'h00);
        lane_case(1'b1, 1'b1, 4'h1, 4'h2, 5'h0b, 5'h06);
        lane_case(1'b0, 1'b1, 4'h0, 4'h1, 5'h04, 5'h11);
        $display("done: lanes");
    endtask
    task t_cal();
        logic [31:0] q;
        logic e;
        int n;
        wr(`DT_OFF_ZCAL, 32'hb1);
        repeat (2) @(posedge clock);
        chk({31'h0, cal_req}, 32'h1);
        chk({24'h0, term_impedance_code, drive_strength_code}, 32'h58);
        n = 0;
        do begin
            apb(1'b0, `DT_OFF_ZCAL, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        chk(q, 32'hb0);
        repeat (3) @(posedge clock);
        chk({31'h0, cal_req}, 32'h0);
        for (int k = 0; k < 7; k++) begin
            n = (k == 0) ? 2 : (k == 1) ? 3 : (k == 2) ? 5 : (k == 3) ? 7 : (k == 4) ? 8
                : (k == 5) ? 11 : 13;
            wr(`DT_OFF_ZCAL, {23'h0, n[3:0], n[3:0], 1'b0});
            rd(`DT_OFF_ZCAL, {23'h0, n[3:0], n[3:0], 1'b0}, 1'b0);
            chk({24'h0, term_impedance_code, drive_strength_code}, {24'h0, n[3:0], n[3:0]});
        end
        $display("done: calibration");
    endtask
    // verdict, single exit
    task tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #1_000_000;
        n_fail++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, rd_cmd, wr_cmd, cmd_cs} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        n_fail = 0;
        tests_run = 0;
        live = 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_odt();
        t_lane();
        t_cal();
        tally_and_finish();
    end
endmodule
